// *** verilog/ilo_offset_core.sv ***
// Indexed literal offset decode and execute for three byte/bit instructions.
// Assumes software loads an instruction over the register port; one clock, async low reset.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "ilo_defs.svh"

// Summary of operation
// (RULE1) Extension on: low access operand is stack offset
// (RULE2) Indexed add: offset 0..95, accumulator plus byte
// (RULE3) Destination bit 0 accumulator, 1 memory
// (RULE4) Add updates N, overflow, carry, digit carry, Z
// (RULE5) Decode add from pattern 0010 01d0 kkkkkkkk
// (RULE6) Bit set sets bit b, flags untouched
// (RULE7) Decode bit set from 1000 bbb0 kkkkkkkk
// (RULE8) Set-all writes FFh, flags untouched
// (RULE9) One word, four phases: decode, read, process, write
// (RULE10) Extension enable resets to 0, disabled
// (RULE11) Indexing only when access 0 and operand <=5Fh
// (RULE12) Disabled: access bank, or bank select when 1
// (RULE13) Address is pointer plus zero-extended offset, pointer kept
// (RULE14) Disabled extension keeps standard meaning and timing
module ilo_offset_core
	import ilo_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	output logic      [7:0]  regRdData,
	output logic             execBusy
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic        ext_instr_enable_r;
	logic [11:0] stack_pointer_reg_r;
	logic [3:0]  bank_select_reg_r;
	logic [7:0]  accum_r;
	logic [4:0]  status_r;
	logic [15:0] instr_r;
	logic [11:0] memAddr_r;
	ilo_phase_t  phase_r;
	ilo_phase_t  phase_nxt;
	ilo_op_t     op_r;
	logic [11:0] effAddr_r;
	logic [7:0]  result_r;
	logic [4:0]  flags_r;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic ilo_op_t decodeOp(input logic [7:0] hi);
		if ((hi & `ILO_ADD_MASK) == `ILO_ADD_CODE)
			decodeOp = ILO_OP_ADD; // RULE5
		else if ((hi & `ILO_BSET_MASK) == `ILO_BSET_CODE)
			decodeOp = ILO_OP_BSET; // RULE7
		else if ((hi & `ILO_SET_FILE_ALL_ONES_MASK) == `ILO_SET_FILE_ALL_ONES_CODE)
			decodeOp = ILO_OP_SET_FILE_ALL_ONES;
		else
			decodeOp = ILO_OP_NONE;
	endfunction

	function automatic logic [7:0] bitMask(input logic [2:0] idx);
		bitMask = 8'h01 << idx;
	endfunction

	// ----------------------------------------
	// Address formation
	// ----------------------------------------
	wire        accessBit = instr_r[`ILO_OP_ACCESS_BIT];
	wire [7:0]  operand   = instr_r[7:0];
	// Operands above 5Fh stay literal, so the upper access area stays reachable
	wire        lowOperand = (operand <= `ILO_OFFSET_MAX);
	wire        useIndex  = ext_instr_enable_r && !accessBit && lowOperand; // RULE1 RULE11
	// Sum wraps at 12 bits; no carry leaves the data space
	// Pointer is only read here, so the indexed form never moves it
	wire [11:0] indexAddr = stack_pointer_reg_r + {4'h0, operand}; // RULE13
	// Access bank: low part of bank 0, upper part at the top of data space
	wire [11:0] accessAddr = lowOperand ? {4'h0, operand} : {`ILO_ACCESS_HIGH, operand}; // RULE12
	wire [11:0] bankAddr  = {bank_select_reg_r, operand}; // RULE12
	wire [11:0] literalAddr = accessBit ? bankAddr : accessAddr; // RULE14
	wire [11:0] effAddr   = useIndex ? indexAddr : literalAddr;

	// ----------------------------------------
	// Processing
	// ----------------------------------------
	wire [7:0] memRdData;
	wire [8:0] sum      = {1'b0, accum_r} + {1'b0, memRdData}; // RULE2
	wire [4:0] nibSum   = {1'b0, accum_r[3:0]} + {1'b0, memRdData[3:0]};
	wire       sumOv    = (accum_r[7] == memRdData[7]) && (sum[7] != accum_r[7]);
	wire [4:0] addFlags;
	assign addFlags[`ILO_ST_N]  = sum[7]; // RULE4
	assign addFlags[`ILO_ST_OV] = sumOv;
	assign addFlags[`ILO_ST_Z]  = (sum[7:0] == 8'h00);
	assign addFlags[`ILO_ST_DC] = nibSum[4];
	assign addFlags[`ILO_ST_C]  = sum[8];

	wire [7:0] bsetData = memRdData | bitMask(instr_r[11:9]); // RULE6
	wire [7:0] procData = (op_r == ILO_OP_ADD)  ? sum[7:0] :
	                      (op_r == ILO_OP_BSET) ? bsetData : `ILO_ALL_ONES; // RULE8
	wire       destMem  = (op_r != ILO_OP_ADD) || instr_r[`ILO_OP_DEST_BIT]; // RULE3

	// ----------------------------------------
	// Phase sequencer
	// ----------------------------------------
	// High-byte write doubles as the start strobe; dropped while busy
	wire startExec = regWrEn && (regAddr == `ILO_REG_INSTRH) && (phase_r == ILO_IDLE);

	always_comb
	begin
		case (phase_r) // RULE9
			ILO_IDLE: phase_nxt = startExec ? ILO_Q1 : ILO_IDLE;
			ILO_Q1:   phase_nxt = ILO_Q2;
			ILO_Q2:   phase_nxt = ILO_Q3;
			ILO_Q3:   phase_nxt = ILO_Q4;
			ILO_Q4:   phase_nxt = ILO_IDLE;
			default:  phase_nxt = ILO_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			phase_r <= ILO_IDLE;
		else
			phase_r <= phase_nxt;
	end

	// Q1 decode, Q2 read operand, Q3 process, Q4 write
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			op_r      <= ILO_OP_NONE;
			effAddr_r <= 12'h000;
		end
		else if (phase_r == ILO_Q1)
		begin
			op_r      <= decodeOp(instr_r[15:8]);
			effAddr_r <= effAddr;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			result_r <= 8'h00;
			flags_r  <= `ILO_STATUS_RESET;
		end
		else if (phase_r == ILO_Q3)
		begin
			result_r <= procData;
			flags_r  <= (op_r == ILO_OP_ADD) ? addFlags : status_r;
		end
	end

	// ----------------------------------------
	// Data space port
	// ----------------------------------------
	wire        idle      = (phase_r == ILO_IDLE);
	// Unknown opcodes run all four phases but leave data space alone
	wire        execWrite = (phase_r == ILO_Q4) && destMem && (op_r != ILO_OP_NONE);
	wire        swWrite   = idle && regWrEn && (regAddr == `ILO_REG_MDATA);
	wire        ramWrEn   = execWrite || swWrite;
	wire [11:0] ramAddr   = idle ? memAddr_r : effAddr_r;
	wire [7:0]  ramWrData = idle ? regWrData : result_r;

	// One shared port; software owns it only while idle
	ilo_data_ram u_ram
	(
		.clk    (sys_clk),
		.rstn   (rstn),
		.wrEn   (ramWrEn),
		.addr   (ramAddr),
		.wrData (ramWrData),
		.rdData (memRdData)
	);

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	wire swWr     = regWrEn && idle;
	wire wrCtrl   = swWr && (regAddr == `ILO_REG_CTRL);
	wire wrSpl    = swWr && (regAddr == `ILO_REG_SPL);
	wire wrSph    = swWr && (regAddr == `ILO_REG_SPH);
	wire wrBank   = swWr && (regAddr == `ILO_REG_BANK);
	wire wrAcc    = swWr && (regAddr == `ILO_REG_ACC);
	wire wrStatus = swWr && (regAddr == `ILO_REG_STATUS);
	wire wrInstrL = swWr && (regAddr == `ILO_REG_INSTRL);
	wire wrMaddrL = swWr && (regAddr == `ILO_REG_MADDRL);
	wire wrMaddrH = swWr && (regAddr == `ILO_REG_MADDRH);
	wire q4       = (phase_r == ILO_Q4);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			ext_instr_enable_r <= `ILO_EXT_RESET; // RULE10
		else if (wrCtrl)
			ext_instr_enable_r <= regWrData[`ILO_CTRL_EXT_BIT];
	end

	// Upper half keeps four bits: data space is 12 bits wide
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			stack_pointer_reg_r <= `ILO_SP_RESET;
		else if (wrSpl)
			stack_pointer_reg_r <= {stack_pointer_reg_r[11:8], regWrData};
		else if (wrSph)
			stack_pointer_reg_r <= {regWrData[3:0], stack_pointer_reg_r[7:0]};
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			bank_select_reg_r <= `ILO_BANK_RESET;
		else if (wrBank)
			bank_select_reg_r <= regWrData[3:0];
	end

	// Q4 load cannot meet a software write, which waits for idle
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			accum_r <= `ILO_ACC_RESET;
		else if (q4 && (op_r == ILO_OP_ADD) && !destMem)
			accum_r <= result_r; // RULE3
		else if (wrAcc)
			accum_r <= regWrData;
	end

	// Bit set and set-all capture the old flags in Q3 and write them back in Q4
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			status_r <= `ILO_STATUS_RESET;
		else if (q4)
			status_r <= flags_r; // RULE4 RULE6 RULE8
		else if (wrStatus)
			status_r <= regWrData[4:0];
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			instr_r <= 16'h0000;
		else if (wrInstrL)
			instr_r <= {instr_r[15:8], regWrData};
		else if (startExec)
			instr_r <= {regWrData, instr_r[7:0]};
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			memAddr_r <= 12'h000;
		else if (wrMaddrL)
			memAddr_r <= {memAddr_r[11:8], regWrData};
		else if (wrMaddrH)
			memAddr_r <= {regWrData[3:0], memAddr_r[7:0]};
	end

	// Taken from the next phase so it tracks the phase register exactly
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			execBusy <= 1'b0;
		else
			execBusy <= (phase_nxt != ILO_IDLE);
	end

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	logic [7:0] rdSel;
	always_comb
	begin
		case (regAddr)
			`ILO_REG_CTRL:   rdSel = {6'h00, ~idle, ext_instr_enable_r};
			`ILO_REG_SPL:    rdSel = stack_pointer_reg_r[7:0];
			`ILO_REG_SPH:    rdSel = {4'h0, stack_pointer_reg_r[11:8]};
			`ILO_REG_BANK:   rdSel = {4'h0, bank_select_reg_r};
			`ILO_REG_ACC:    rdSel = accum_r;
			`ILO_REG_STATUS: rdSel = {3'h0, status_r};
			`ILO_REG_INSTRL: rdSel = instr_r[7:0];
			`ILO_REG_INSTRH: rdSel = instr_r[15:8];
			`ILO_REG_MADDRL: rdSel = memAddr_r[7:0];
			`ILO_REG_MADDRH: rdSel = {4'h0, memAddr_r[11:8]};
			`ILO_REG_MDATA:  rdSel = memRdData;
			default:         rdSel = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			regRdData <= 8'h00;
		else if (regRdEn)
			regRdData <= rdSel;
	end
endmodule

// *** verilog/ilo_defs.svh ***
// Offsets, field positions, reset values and opcode patterns of the indexed offset core.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ILO_DEFS_SVH
`define ILO_DEFS_SVH

// ----------------------------------------
// Register port offsets
// ----------------------------------------
`define ILO_REG_CTRL      4'h0
`define ILO_REG_SPL       4'h1
`define ILO_REG_SPH       4'h2
`define ILO_REG_BANK      4'h3
`define ILO_REG_ACC       4'h4
`define ILO_REG_STATUS    4'h5
`define ILO_REG_INSTRL    4'h6
`define ILO_REG_INSTRH    4'h7
`define ILO_REG_MADDRL    4'h8
`define ILO_REG_MADDRH    4'h9
`define ILO_REG_MDATA     4'hA

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ILO_CTRL_EXT_BIT  0
`define ILO_CTRL_BUSY_BIT 1
`define ILO_ST_N          4
`define ILO_ST_OV         3
`define ILO_ST_Z          2
`define ILO_ST_DC         1
`define ILO_ST_C          0
`define ILO_OP_ACCESS_BIT 8
`define ILO_OP_DEST_BIT   9

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define ILO_EXT_RESET     1'h0
`define ILO_SP_RESET      12'h000
`define ILO_BANK_RESET    4'h0
`define ILO_ACC_RESET     8'h00
`define ILO_STATUS_RESET  5'h00
`define ILO_OFFSET_MAX    8'h5F
`define ILO_ACCESS_HIGH   4'hF
`define ILO_ALL_ONES      8'hFF

// ----------------------------------------
// Opcode patterns (masked compare on the high byte)
// ----------------------------------------
`define ILO_ADD_MASK      8'hFC
`define ILO_ADD_CODE      8'h24
`define ILO_BSET_MASK     8'hF0
`define ILO_BSET_CODE     8'h80
`define ILO_SET_FILE_ALL_ONES_MASK     8'hFE
`define ILO_SET_FILE_ALL_ONES_CODE     8'h68

`endif

// *** verilog/ilo_pkg.sv ***
// Types used by the indexed offset core; the testbench does not import them.
// Assumes ilo_defs.svh is on the include path.
package ilo_pkg;
	`include "ilo_defs.svh"

	typedef enum logic [4:0] {
		ILO_IDLE = 5'h01,
		ILO_Q1   = 5'h02,
		ILO_Q2   = 5'h04,
		ILO_Q3   = 5'h08,
		ILO_Q4   = 5'h10
	} ilo_phase_t;

	typedef enum logic [3:0] {
		ILO_OP_NONE = 4'h1,
		ILO_OP_ADD  = 4'h2,
		ILO_OP_BSET = 4'h4,
		ILO_OP_SET_FILE_ALL_ONES = 4'h8
	} ilo_op_t;
endpackage

// *** verilog/ilo_data_ram.sv ***
// Byte-wide data space of the core, one read/write port.
// Assumes a single clock; read data are registered and appear one cycle after the address.
`timescale 1ns/10ps
module ilo_data_ram
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        wrEn,
	input  wire logic [11:0] addr,
	input  wire logic [7:0]  wrData,
	output logic      [7:0]  rdData
);
	logic [7:0] mem [0:4095];

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Array has no reset, so it maps onto block memory
	always_ff @(posedge clk)
	begin
		if (wrEn)
			mem[addr] <= wrData;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdData <= 8'h00;
		else
			rdData <= mem[addr];
	end
endmodule

// *** test/ilo_offset_core_chk.sv ***
// Port checker for the indexed offset core.
// Assumes one clock, active-low async reset, writes refused while busy.
`timescale 1ns/10ps
module ilo_offset_core_chk
(
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrEn,
	input wire logic       regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic       execBusy
);
	// ----
	// Shadows of accepted writes and a busy cycle count
	// ----
	logic       ext_r;
	logic [7:0] spl_r;
	logic [3:0] bank_r;
	logic [2:0] busyCnt_r;
	wire        wrOk = regWrEn && !execBusy;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ext_r     <= 1'h0;
			spl_r     <= 8'h00;
			bank_r    <= 4'h0;
			busyCnt_r <= 3'h0;
		end
		else
		begin
			if (wrOk && regAddr == 4'h0) ext_r <= regWrData[0];
			if (wrOk && regAddr == 4'h1) spl_r <= regWrData;
			if (wrOk && regAddr == 4'h3) bank_r <= regWrData[3:0];
			busyCnt_r <= execBusy ? busyCnt_r + 3'h1 : 3'h0;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_exec_len: assert property (
		regWrEn && regAddr == 4'h7 && !execBusy |=> execBusy [*4] ##1 !execBusy) else $error("busy length");
	a_busy_cause: assert property (
		$rose(execBusy) |-> $past(regWrEn) && $past(regAddr) == 4'h7) else $error("busy without start");
	a_busy_max: assert property (execBusy |-> busyCnt_r < 3'h4) else $error("busy too long");
	a_ctrl_ext: assert property (
		regRdEn && regAddr == 4'h0 |=> regRdData[0] == ext_r) else $error("ext enable value");
	a_ctrl_busy: assert property (
		regRdEn && regAddr == 4'h0 |=> regRdData[1] == $past(execBusy)) else $error("busy bit value");
	a_spl_track: assert property (
		regRdEn && regAddr == 4'h1 |=> regRdData == spl_r) else $error("pointer low changed");
	a_bank_track: assert property (
		regRdEn && regAddr == 4'h3 |=> regRdData[3:0] == bank_r) else $error("bank value");
	a_unmapped_rd: assert property (regRdEn && regAddr > 4'hA |=> regRdData == 8'h00) else $error("unmapped read");
	a_rd_hold: assert property (!regRdEn |=> $stable(regRdData)) else $error("read data moved");
endmodule

// *** test/ilo_offset_core_bench.sv ***
// Bench for the indexed offset core: instruction table, then reset and edge cases.
// Assumes the checker module is compiled before this file.
`timescale 1ns/10ps
module ilo_offset_core_bench;
	typedef struct {
		logic ext; logic [15:0] ins; logic [11:0] sp; logic [3:0] bk;
		logic [7:0] acc, mem; logic [11:0] ea; logic [7:0] xm, xa; logic [4:0] xs;
	} ilo_row_t;
	logic       sys_clk   = 1'b0;
	logic       rstn      = 1'b0;
	logic [3:0] regAddr   = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic       regWrEn   = 1'b0;
	logic       regRdEn   = 1'b0;
	wire  [7:0] regRdData;
	wire        execBusy;
	int         mismatches = 0;
	int         num_checks = 0;
	int         cyc        = 0;
	int         n;
	logic [7:0] d;
	// STATUS is preset to 15h; only the add may change it
	ilo_row_t   rows [11] = '{
		'{1'h1,16'h262C,12'hA00,4'h0,8'h17,8'h20,12'hA2C,8'h37,8'h17,5'h00},
		'{1'h1,16'h245F,12'hFF0,4'h0,8'h88,8'h88,12'h04F,8'h88,8'h10,5'h0B},
		'{1'h1,16'h2400,12'h123,4'h0,8'h7F,8'h01,12'h123,8'h01,8'h80,5'h1A},
		'{1'h1,16'h2410,12'h200,4'h0,8'hFF,8'h01,12'h210,8'h01,8'h00,5'h07},
		'{1'h1,16'h8E0A,12'hA00,4'h0,8'h17,8'h55,12'hA0A,8'hD5,8'h17,5'h15},
		'{1'h1,16'h8030,12'h000,4'h0,8'h17,8'h00,12'h030,8'h01,8'h17,5'h15},
		'{1'h1,16'h682C,12'hA00,4'h0,8'h17,8'h00,12'hA2C,8'hFF,8'h17,5'h15},
		'{1'h1,16'h6860,12'hA00,4'h0,8'h17,8'h00,12'hF60,8'hFF,8'h17,5'h15},
		'{1'h1,16'h692C,12'hA00,4'h5,8'h17,8'h00,12'h52C,8'hFF,8'h17,5'h15},
		'{1'h0,16'h262C,12'hA00,4'h0,8'h01,8'h02,12'h02C,8'h03,8'h01,5'h00},
		'{1'h0,16'h8780,12'hA00,4'h3,8'h17,8'h00,12'h380,8'h08,8'h17,5'h15}
	};
	ilo_offset_core DUT (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .execBusy(execBusy));
	initial forever #10 sys_clk = ~sys_clk;
	// ----
	// Bus and compare tasks
	// ----
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		regAddr   <= a;
		regWrData <= v;
		regWrEn   <= 1'b1;
		regRdEn   <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		regAddr <= a;
		regRdEn <= 1'b1;
		regWrEn <= 1'b0;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		@(negedge sys_clk);
		v = regRdData;
		@(posedge sys_clk);
	endtask
	task automatic idle(input int k);
		regWrEn <= 1'b0;
		regRdEn <= 1'b0;
		repeat (k) @(posedge sys_clk);
	endtask
	task automatic cmp(input logic [11:0] g, input logic [11:0] e);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Counts busy cycles seen at falling edges, bounded
	task automatic wt();
		regWrEn <= 1'b0;
		n = 0;
		@(negedge sys_clk);
		while (execBusy === 1'b1 && n < 10)
		begin
			@(negedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
	endtask
	task automatic exe(input logic [15:0] ins);
		wr(4'h6, ins[7:0]);
		wr(4'h7, ins[15:8]);
		wt();
		cmp(12'(n), 12'h004);
	endtask
	task automatic run(input ilo_row_t r);
		wr(4'h0, {7'h00, r.ext});
		wr(4'h1, r.sp[7:0]);
		wr(4'h2, {4'h0, r.sp[11:8]});
		wr(4'h3, {4'h0, r.bk});
		wr(4'h4, r.acc);
		wr(4'h5, 8'h15);
		wr(4'h8, r.ea[7:0]);
		wr(4'h9, {4'h0, r.ea[11:8]});
		wr(4'hA, r.mem);
		exe(r.ins);
		idle(2);
		rd(4'hA, d);
		cmp(d, r.xm);
		rd(4'h4, d);
		cmp(d, r.xa);
		rd(4'h5, d);
		cmp(d[4:0], r.xs);
		rd(4'h1, d);
		cmp(d, r.sp[7:0]);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	// ----
	// Sequence
	// ----
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		rd(4'h0, d);
		cmp(d, 8'h00);
		$display("reset values done");
		foreach (rows[i])
		begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		wr(4'h0, 8'h01);
		wr(4'h1, 8'h00);
		wr(4'h2, 8'h01);
		wr(4'h8, 8'h05);
		wr(4'h9, 8'h01);
		wr(4'hA, 8'h00);
		for (int b = 0; b < 8; b++)
			exe({4'h8, 3'(b), 1'b0, 8'h05});
		idle(2);
		rd(4'hA, d);
		cmp(d, 8'hFF);
		$display("bit index sweep done");
		// Pointer write lands in the first busy cycle and must be dropped
		wr(4'h6, 8'h00);
		wr(4'h7, 8'h00);
		wr(4'h1, 8'h77);
		wt();
		cmp(12'(n), 12'h003);
		rd(4'h1, d);
		cmp(d, 8'h00);
		wr(4'hC, 8'h5A);
		rd(4'hC, d);
		cmp(d, 8'h00);
		$display("refused and unmapped done");
		// Control read in Q1 shows busy beside the enable
		wr(4'h6, 8'h00);
		wr(4'h7, 8'h00);
		rd(4'h0, d);
		cmp(d, 8'h03);
		wt();
		cmp(12'(n), 12'h002);
		$display("busy read-back done");
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		rd(4'h0, d);
		cmp(d, 8'h00);
		$display("second reset done");
		end_of_test();
	end
endmodule
bind ilo_offset_core ilo_offset_core_chk CHK (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
	.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .execBusy(execBusy));
